// ==== include/bse_pkg.sv ====
// Package for the bit-set execution block: encodings, layouts and types
package bse_pkg;

	// ************************************************************
	// Widths
	// ************************************************************
	localparam int BSE_DATA_W = 8;
	localparam int BSE_BANK_W = 4;
	localparam int BSE_FILE_W = 8;
	localparam int BSE_ADDR_W = BSE_BANK_W + BSE_FILE_W;
	localparam int BSE_BIT_W = 3;

	// ************************************************************
	// Instruction word layout
	// ************************************************************
	localparam int BSE_OPC_MSB = 15;
	localparam int BSE_OPC_LSB = 12;
	localparam int BSE_BIT_MSB = 11;
	localparam int BSE_BIT_LSB = 9;
	localparam int BSE_BANKSEL_POS = 8;
	localparam int BSE_FILE_MSB = 7;
	localparam int BSE_FILE_LSB = 0;
	localparam logic [3:0] BSE_OPC_SET = 4'h8;

	// ************************************************************
	// Access bank and indexed offset limits
	// ************************************************************
	localparam logic [BSE_FILE_W-1:0] BSE_ACCESS_LOW_MAX = 8'h5F;
	localparam logic [BSE_BANK_W-1:0] BSE_ACCESS_LOW_BANK = 4'h0;
	localparam logic [BSE_BANK_W-1:0] BSE_ACCESS_HIGH_BANK = 4'hF;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [BSE_ADDR_W-1:0] BSE_ADDR_RST = 12'h000;
	localparam logic [BSE_DATA_W-1:0] BSE_DATA_RST = 8'h00;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [3:0] {
		BSE_ST_DECODE = 4'h1,
		BSE_ST_READ = 4'h2,
		BSE_ST_PROCESS = 4'h4,
		BSE_ST_WRITE = 4'h8
	} bse_state_t;

	typedef struct packed {
		logic [BSE_BIT_W-1:0] bit_sel;
		logic bank_choice;
		logic [BSE_FILE_W-1:0] file_addr;
	} bse_instr_t;

	typedef struct packed {
		logic [BSE_ADDR_W-1:0] addr;
		logic rd;
		logic wr;
		logic [BSE_DATA_W-1:0] wdata;
	} bse_mem_req_t;

endpackage : bse_pkg

// ==== hdl/bse_exec.sv ====
// Execution logic of the four-phase (decode, read, process, write) bit-set-file operation
`timescale 1ns/10ps

module bse_exec
	#(
	parameter int ADDR_W = bse_pkg::BSE_ADDR_W,
	parameter int BANK_W = bse_pkg::BSE_BANK_W,
	parameter int DATA_W = bse_pkg::BSE_DATA_W
	)
	(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	input wire logic ext_set_en,
	input wire logic [bse_pkg::BSE_BANK_W-1:0] bank_select_register,
	input wire logic [bse_pkg::BSE_ADDR_W-1:0] index_base,
	input wire logic [bse_pkg::BSE_DATA_W-1:0] mem_rdata,
	output bse_pkg::bse_mem_req_t mem_req,
	output logic busy,
	output logic done,
	output logic status_we
	);

	import bse_pkg::*;

	// ************************************************************
	// Parameter checks
	// ************************************************************
	// Field layout is fixed by the instruction word, so only the
	// documented widths can be served.
	generate
		if (ADDR_W != BSE_ADDR_W || BANK_W != BSE_BANK_W ||
			DATA_W != BSE_DATA_W)
		begin : g_bad_param
			$error("bse_exec: unsupported width parameters");
		end
	endgenerate

	// ************************************************************
	// Functions
	// ************************************************************
	function automatic logic [BSE_DATA_W-1:0] bit_mask
		(input logic [BSE_BIT_W-1:0] sel);
		logic [BSE_DATA_W-1:0] m;
		m = {{(BSE_DATA_W-1){1'b0}}, 1'b1};
		bit_mask = m << sel;
	endfunction : bit_mask

	function automatic logic [BSE_ADDR_W-1:0] general_purpose_register_addr
		(input bse_instr_t ins,
		 input logic ext_en,
		 input logic [BSE_BANK_W-1:0] bank,
		 input logic [BSE_ADDR_W-1:0] base);
		logic [BSE_ADDR_W-1:0] a;
		a = BSE_ADDR_RST;
		if (ins.bank_choice)
		begin
			a = {bank, ins.file_addr};
		end
		else if (ext_en && ins.file_addr <= BSE_ACCESS_LOW_MAX)
		begin
			// Offset from the index pointer; wraps within the space
			a = BSE_ADDR_W'(base + {{BSE_BANK_W{1'b0}}, ins.file_addr});
		end
		else if (ins.file_addr <= BSE_ACCESS_LOW_MAX)
		begin
			a = {BSE_ACCESS_LOW_BANK, ins.file_addr};
		end
		else
		begin
			a = {BSE_ACCESS_HIGH_BANK, ins.file_addr};
		end
		general_purpose_register_addr = a;
	endfunction : general_purpose_register_addr

	// ************************************************************
	// Decode
	// ************************************************************
	bse_state_t state;
	bse_instr_t decoded;
	bse_instr_t held;
	logic is_set_op;
	logic accept;

	assign decoded.bit_sel = instr_word[BSE_BIT_MSB:BSE_BIT_LSB];
	assign decoded.bank_choice = instr_word[BSE_BANKSEL_POS];
	assign decoded.file_addr = instr_word[BSE_FILE_MSB:BSE_FILE_LSB];
	// Other opcodes are left to their own executors
	assign is_set_op = instr_word[BSE_OPC_MSB:BSE_OPC_LSB] == BSE_OPC_SET;
	assign accept = state == BSE_ST_DECODE && instr_valid && is_set_op;

	// ************************************************************
	// Phase sequencer
	// ************************************************************
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			state <= BSE_ST_DECODE;
		end
		else
		begin
			case (state)
				BSE_ST_DECODE:
				begin
					if (accept)
					begin
						state <= BSE_ST_READ;
					end
				end
				BSE_ST_READ:
				begin
					state <= BSE_ST_PROCESS;
				end
				BSE_ST_PROCESS:
				begin
					state <= BSE_ST_WRITE;
				end
				BSE_ST_WRITE:
				begin
					state <= BSE_ST_DECODE;
				end
				default:
				begin
					state <= BSE_ST_DECODE;
				end
			endcase
		end
	end

	// Operand capture: later word changes do not disturb the write
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			held <= '0;
		end
		else if (accept)
		begin
			held <= decoded;
		end
	end

	// ************************************************************
	// Memory request
	// ************************************************************
	logic [BSE_ADDR_W-1:0] req_addr;
	logic req_rd;
	logic req_wr;
	logic [BSE_DATA_W-1:0] req_wdata;

	// One driver for the whole bundle; every field is a flop
	assign mem_req = {req_addr, req_rd, req_wr, req_wdata};

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			req_addr <= BSE_ADDR_RST;
		end
		else if (accept)
		begin
			// Address resolved once; the same word is read and written
			req_addr <= general_purpose_register_addr(decoded,
				ext_set_en, bank_select_register, index_base);
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			req_rd <= 1'b0;
		end
		else
		begin
			req_rd <= accept;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			req_wdata <= BSE_DATA_RST;
			req_wr <= 1'b0;
		end
		else if (state == BSE_ST_PROCESS)
		begin
			req_wdata <= mem_rdata | bit_mask(held.bit_sel);
			req_wr <= 1'b1;
		end
		else
		begin
			req_wr <= 1'b0;
		end
	end

	// ************************************************************
	// Status
	// ************************************************************
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			busy <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			if (accept)
			begin
				busy <= 1'b1;
			end
			else if (state == BSE_ST_WRITE)
			begin
				busy <= 1'b0;
			end
			done <= state == BSE_ST_WRITE;
		end
	end

	// Flag write enable held low: this operation never alters flags
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			status_we <= 1'b0;
		end
		else
		begin
			status_we <= 1'b0;
		end
	end

endmodule : bse_exec

// ==== tb/bse_exec_monitor.sv ====
// Checker for the bit-set execution block
`timescale 1ns/10ps
module bse_exec_monitor
	(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	input wire logic ext_set_en,
	input wire logic [bse_pkg::BSE_BANK_W-1:0] bank_select_register,
	input wire logic [bse_pkg::BSE_ADDR_W-1:0] index_base,
	input wire logic [bse_pkg::BSE_DATA_W-1:0] mem_rdata,
	input wire bse_pkg::bse_mem_req_t mem_req,
	input wire logic busy,
	input wire logic done,
	input wire logic status_we
	);
	import bse_pkg::*;
	logic acc;
	logic low;
	logic [7:0] f;
	assign f = instr_word[7:0];
	assign low = f <= BSE_ACCESS_LOW_MAX;
	assign acc = instr_valid && !busy && instr_word[15:12] == BSE_OPC_SET;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	phase_order_a: assert property (
		acc |=> mem_req.rd ##2 mem_req.wr ##1 done)
		else $error("phase order broken");
	refuse_idle_a: assert property (
		!busy && !acc |=> !mem_req.rd)
		else $error("read without accepted word");
	flags_kept_a: assert property (!status_we)
		else $error("flag write seen");
	set_bit_a: assert property (
		acc |-> ##3 mem_req.wr && mem_req.wdata ==
		($past(mem_rdata) | (8'h01 << $past(instr_word[11:9], 3))))
		else $error("wrong write data");
	bank_addr_a: assert property (
		acc && instr_word[8] |=>
		mem_req.addr == {$past(bank_select_register), $past(f)})
		else $error("wrong banked address");
	access_addr_a: assert property (
		acc && !instr_word[8] && !(ext_set_en && low) |=>
		mem_req.addr == {($past(f) > 8'h5F) ? 4'hF : 4'h0, $past(f)})
		else $error("wrong access address");
	index_addr_a: assert property (
		acc && !instr_word[8] && ext_set_en && low |=>
		mem_req.addr == $past(index_base) + $past(f))
		else $error("wrong indexed address");
	cover property (acc && instr_word[8]);
	cover property (acc && ext_set_en && low);
	cover property (done);
endmodule : bse_exec_monitor

bind bse_exec bse_exec_monitor u_mon (.core_clk, .rst_b, .instr_valid,
	.instr_word, .ext_set_en, .bank_select_register, .index_base, .mem_rdata,
	.mem_req, .busy, .done, .status_we);

// ==== tb/bse_mem_model.sv ====
// Data memory model with one-cycle read latency
`timescale 1ns/10ps
module bse_mem_model
	(
	input wire logic core_clk,
	input wire bse_pkg::bse_mem_req_t mem_req,
	output logic [bse_pkg::BSE_DATA_W-1:0] mem_rdata
	);
	import bse_pkg::*;
	logic [BSE_DATA_W-1:0] mem [0:4095];
	// Data flips outside the read slot so a late sample is caught
	always_ff @(posedge core_clk)
	begin
		mem_rdata <= mem_req.rd ? mem[mem_req.addr] : ~mem_rdata;
	end

	// Plain process: the bench also preloads words between operations
	always @(posedge core_clk)
	begin
		if (mem_req.wr)
		begin
			mem[mem_req.addr] <= mem_req.wdata;
		end
	end
endmodule : bse_mem_model

// ==== tb/bse_exec_tb.sv ====
// Self-checking bench for the bit-set execution block
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
	$display("unexpected %0t value %h", $time, a); end end
module bse_exec_tb;
	import bse_pkg::*;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic instr_valid = 1'b0;
	logic [15:0] instr_word = 16'h0000;
	logic ext_set_en = 1'b0;
	logic [BSE_BANK_W-1:0] bank_select_register = 4'h3;
	logic [BSE_ADDR_W-1:0] index_base = 12'hFF0;
	logic [BSE_DATA_W-1:0] mem_rdata;
	bse_mem_req_t mem_req;
	logic busy;
	logic done;
	logic status_we;
	int n_fail = 0;
	int checks = 0;
	bse_exec DUT (.core_clk(core_clk), .rst_b(rst_b),
		.instr_valid(instr_valid), .instr_word(instr_word),
		.ext_set_en(ext_set_en), .bank_select_register(bank_select_register),
		.index_base(index_base), .mem_rdata(mem_rdata), .mem_req(mem_req),
		.busy(busy), .done(done), .status_we(status_we));
	bse_mem_model u_mem (.core_clk(core_clk), .mem_req(mem_req),
		.mem_rdata(mem_rdata));
	initial forever #5 core_clk = ~core_clk;
	// ****************************
	// Tasks
	// ****************************
	// One word for one cycle; done must follow in the fourth cycle
	task automatic issue(input logic [15:0] w, input logic x);
		int n;
		@(negedge core_clk);
		instr_word = w;
		ext_set_en = x;
		instr_valid = 1'b1;
		@(negedge core_clk);
		instr_valid = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 8)
		begin
			@(negedge core_clk);
			n++;
		end
		`CHK(done, 1'b1)
		`CHK(n, 3)
		`CHK(status_we, 1'b0)
	endtask : issue
	task automatic access_scenario;
		u_mem.mem[12'h05F] = 8'h0A;
		issue(16'h8E5F, 1'b0);
		`CHK(u_mem.mem[12'h05F], 8'h8A)
		u_mem.mem[12'hF60] = 8'h00;
		issue(16'h8060, 1'b0);
		`CHK(u_mem.mem[12'hF60], 8'h01)
	endtask : access_scenario
	task automatic banked_scenario;
		u_mem.mem[12'h310] = 8'h00;
		issue(16'h8710, 1'b1);
		`CHK(u_mem.mem[12'h310], 8'h08)
		bank_select_register = 4'hA;
		u_mem.mem[12'hA10] = 8'h00;
		issue(16'h8F10, 1'b0);
		`CHK(u_mem.mem[12'hA10], 8'h80)
	endtask : banked_scenario
	task automatic indexed_scenario;
		u_mem.mem[12'h010] = 8'h00;
		issue(16'h8020, 1'b1);
		`CHK(u_mem.mem[12'h010], 8'h01)
		// Top of the offset range still indexes, and wraps the space
		u_mem.mem[12'h04F] = 8'h00;
		issue(16'h8C5F, 1'b1);
		`CHK(u_mem.mem[12'h04F], 8'h40)
		u_mem.mem[12'hF60] = 8'h01;
		issue(16'h8260, 1'b1);
		`CHK(u_mem.mem[12'hF60], 8'h03)
	endtask : indexed_scenario
	task automatic every_bit_scenario;
		logic [7:0] e;
		e = 8'h00;
		u_mem.mem[12'h040] = e;
		for (int i = 0; i < 8; i++)
		begin
			issue({4'h8, i[2:0], 9'h040}, 1'b0);
			e = e | (8'h01 << i);
			`CHK(u_mem.mem[12'h040], e)
		end
	endtask : every_bit_scenario
	task automatic refused_scenario;
		u_mem.mem[12'h040] = 8'h00;
		@(negedge core_clk);
		instr_word = 16'h9040;
		instr_valid = 1'b1;
		@(negedge core_clk);
		instr_valid = 1'b0;
		`CHK(busy, 1'b0)
		`CHK(mem_req.rd, 1'b0)
		repeat (4) @(negedge core_clk);
		`CHK(u_mem.mem[12'h040], 8'h00)
		`CHK(busy, 1'b0)
	endtask : refused_scenario
	task automatic busy_scenario;
		u_mem.mem[12'h020] = 8'h00;
		u_mem.mem[12'h021] = 8'h00;
		@(negedge core_clk);
		instr_word = 16'h8020;
		ext_set_en = 1'b0;
		instr_valid = 1'b1;
		@(negedge core_clk);
		// A second word offered while busy must be dropped
		instr_word = 16'h8021;
		@(negedge core_clk);
		instr_valid = 1'b0;
		repeat (4) @(negedge core_clk);
		`CHK(u_mem.mem[12'h020], 8'h01)
		`CHK(u_mem.mem[12'h021], 8'h00)
	endtask : busy_scenario
	task final_report;
		if (n_fail == 0 && checks > 0)
		begin
			$display("TEST PASSED");
		end
		else
		begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report
	initial
	begin
		#100000;
		n_fail++;
		final_report();
	end
	initial
	begin
		repeat (3) @(negedge core_clk);
		rst_b = 1'b1;
		access_scenario();
		banked_scenario();
		indexed_scenario();
		every_bit_scenario();
		refused_scenario();
		busy_scenario();
		final_report();
	end
endmodule : bse_exec_tb
